// file: hdl/cae_pkg.sv
// constants, operation codes and register map of the arithmetic and i/o execution core
package cae_pkg;

  // ************************************************************
  // software register offsets
  // ************************************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DST = 8'h01;
  localparam logic [7:0] REG_SRC = 8'h02;
  localparam logic [7:0] REG_ADDR_LO = 8'h03;
  localparam logic [7:0] REG_ADDR_HI = 8'h04;
  localparam logic [7:0] REG_BIT = 8'h05;
  localparam logic [7:0] REG_SREG = 8'h06;
  localparam logic [7:0] REG_STATUS = 8'h07;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_FILE_BASE = 8'h20;
  localparam logic [7:0] REG_FILE_LAST = 8'h3f;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int SREG_C = 0;
  localparam int SREG_Z = 1;
  localparam int SREG_N = 2;
  localparam int SREG_V = 3;
  localparam int SREG_S = 4;
  localparam int SREG_H = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;
  localparam int STAT_ERR = 2;
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;

  // ************************************************************
  // i/o space layout
  // ************************************************************
  localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
  localparam logic [7:0] IO_BIT_LAST = 8'h1f;
  localparam logic [7:0] IO_LAST = 8'h3f;
  localparam logic [15:0] EXT_IO_FIRST = 16'h0060;
  localparam logic [15:0] EXT_IO_LAST = 16'h01ff;
  localparam logic [5:0] LOCAL_FLAG_IO = 6'h1a;

  // ************************************************************
  // operation codes, written to the command register
  // ************************************************************
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMM, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY,
    OP_SUB_CARRY_IMM, OP_WORD_SUB_IMM, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
    OP_XOR, OP_SET_BITS, OP_CLR_BITS, OP_TEST, OP_IO_BIT_SET, OP_IO_BIT_CLR,
    OP_SKIP_BIT_SET, OP_SKIP_BIT_CLR, OP_IO_IN, OP_IO_OUT, OP_LOAD_DIRECT,
    OP_STORE_DIRECT
  } cae_op_t;

endpackage

// file: hdl/cae_alu.sv
// combinational byte and word arithmetic with status flag update
`timescale 1ns/1ps
module cae_alu (
  // operation
  input wire cae_pkg::cae_op_t op,
  // byte operands and status in
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] sregIn,
  // word operands
  input wire logic [15:0] wordIn,
  input wire logic [5:0] wordK,
  // results
  output logic [7:0] res,
  output logic [15:0] wordRes,
  output logic [7:0] sregOut
);

  // ************************************************************
  // result and flag computation
  // ************************************************************
  always_comb begin
    logic [8:0] s9;
    logic [16:0] s17;
    logic ci;
    s9 = 9'h000;
    s17 = 17'h00000;
    ci = 1'b0;
    res = a;
    wordRes = wordIn;
    sregOut = sregIn; // unlisted flags keep their value
    if (op == cae_pkg::OP_ADD_CARRY || op == cae_pkg::OP_SUB_CARRY ||
        op == cae_pkg::OP_SUB_CARRY_IMM) begin
      ci = sregIn[cae_pkg::SREG_C];
    end
    unique case (op)
      cae_pkg::OP_ADD, cae_pkg::OP_ADD_CARRY: begin
        s9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        res = s9[7:0];
        sregOut[cae_pkg::SREG_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
        sregOut[cae_pkg::SREG_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
        sregOut[cae_pkg::SREG_C] = s9[8];
        sregOut[cae_pkg::SREG_N] = res[7];
        sregOut[cae_pkg::SREG_Z] = (res == 8'h00);
      end
      cae_pkg::OP_SUB, cae_pkg::OP_SUB_IMM, cae_pkg::OP_SUB_CARRY,
      cae_pkg::OP_SUB_CARRY_IMM: begin
        s9 = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        res = s9[7:0];
        sregOut[cae_pkg::SREG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
        sregOut[cae_pkg::SREG_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
        sregOut[cae_pkg::SREG_C] = s9[8];
        sregOut[cae_pkg::SREG_N] = res[7];
        sregOut[cae_pkg::SREG_Z] = (res == 8'h00);
      end
      cae_pkg::OP_WORD_ADD_IMM, cae_pkg::OP_WORD_SUB_IMM: begin
        if (op == cae_pkg::OP_WORD_ADD_IMM) begin
          s17 = {1'b0, wordIn} + {11'h000, wordK};
          wordRes = s17[15:0];
          sregOut[cae_pkg::SREG_V] = ~wordIn[15] & wordRes[15];
          sregOut[cae_pkg::SREG_C] = ~wordRes[15] & wordIn[15];
        end else begin
          s17 = {1'b0, wordIn} - {11'h000, wordK};
          wordRes = s17[15:0];
          sregOut[cae_pkg::SREG_V] = wordIn[15] & ~wordRes[15];
          sregOut[cae_pkg::SREG_C] = wordRes[15] & ~wordIn[15];
        end
        sregOut[cae_pkg::SREG_N] = wordRes[15];
        sregOut[cae_pkg::SREG_Z] = (wordRes == 16'h0000);
        sregOut[cae_pkg::SREG_S] = wordRes[15] ^ sregOut[cae_pkg::SREG_V];
      end
      cae_pkg::OP_AND, cae_pkg::OP_AND_IMM, cae_pkg::OP_OR, cae_pkg::OP_OR_IMM,
      cae_pkg::OP_XOR, cae_pkg::OP_SET_BITS, cae_pkg::OP_CLR_BITS,
      cae_pkg::OP_TEST: begin
        if (op == cae_pkg::OP_AND || op == cae_pkg::OP_AND_IMM) begin
          res = a & b;
        end else if (op == cae_pkg::OP_OR || op == cae_pkg::OP_OR_IMM) begin
          res = a | b;
        end else if (op == cae_pkg::OP_XOR) begin
          res = a ^ b;
        end else if (op == cae_pkg::OP_SET_BITS) begin
          res = a | b;
        end else if (op == cae_pkg::OP_CLR_BITS) begin
          res = a & (cae_pkg::BYTE_ONES - b);
        end else begin
          res = a & a;
        end
        sregOut[cae_pkg::SREG_V] = 1'b0;
        sregOut[cae_pkg::SREG_N] = res[7];
        sregOut[cae_pkg::SREG_Z] = (res == 8'h00);
      end
      default: ;
    endcase
  end

endmodule

// file: hdl/cae_bit_rmw.sv
// single bit test and read-modify-write value of an i/o register byte
`timescale 1ns/1ps
module cae_bit_rmw (
  // byte read from the i/o register
  input wire logic [7:0] readVal,
  // bit select and direction
  input wire logic [2:0] bitSel,
  input wire logic setBit,
  // whole byte to write back and the tested bit
  output logic [7:0] writeVal,
  output logic bitVal
);

  // ************************************************************
  // modify one bit, pass every other bit back as read
  // ************************************************************
  always_comb begin
    writeVal = readVal; // set flags go back as one and get cleared
    writeVal[bitSel] = setBit;
    bitVal = readVal[bitSel];
  end

endmodule

// file: hdl/cae_core.sv
// execution core: register file, status register, alu operations and i/o access sequencer
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps

// Operation
// - add source (plus carry) into destination in one cycle, Z C N V H
// - word add immediate on register pair in two cycles, Z C N V S
// - subtract register or constant in one cycle, Z C N V H
// - subtract operand and carry in one cycle, Z C N V H
// - word subtract immediate on register pair in two cycles, Z C N V S
// - and with register or constant in one cycle, only Z N V
// - or with register or constant in one cycle, only Z N V
// - xor of two registers in one cycle, Z N V
// - set bits ors constant mask in one cycle, Z N V
// - clear bits ands with 0xff minus constant in one cycle, Z N V
// - test ands register with itself, value unchanged, Z N V
// - single bit set and clear reach only i/o 0x00 to 0x1f
// - skip on bit set or clear tests any bit in that range
// - some flags clear on written one, written zero leaves them
// - bit set and clear rewrite the whole register, clearing set flags
// - i/o in and out address locations 0x00 to 0x3f
// - data space sees i/o at plus 0x20; extended region only by load/store
module cae_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // data space port to i/o registers and memory
  output logic [15:0] dataAddr,
  output logic [7:0] dataWdata,
  output logic dataWe,
  output logic dataRe,
  input wire logic [7:0] dataRdata,
  // event pulses that set the local flag register
  input wire logic [7:0] flagEvent,
  // state
  output logic busy,
  output logic skip
);

  // ************************************************************
  // types and storage
  // ************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_WORD, ST_ACCESS, ST_CAPTURE, ST_WRITE} cae_state_t;

  cae_state_t state_r;
  cae_state_t state_nxt;
  cae_pkg::cae_op_t op_r;
  logic [7:0] regFile [0:31];
  logic [4:0] opDst_r;
  logic [7:0] opSrc_r;
  logic [15:0] opAddr_r;
  logic [2:0] opBit_r;
  logic [7:0] sreg_r;
  logic [7:0] flags_r;
  logic err_r;
  logic skip_r;
  logic busy_r;
  logic [7:0] rdata_r;
  logic [15:0] dataAddr_r;
  logic [7:0] dataWdata_r;
  logic dataWe_r;
  logic dataRe_r;

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic [15:0] ioToData(input logic [5:0] ioAddr);
    ioToData = {10'h000, ioAddr} + cae_pkg::IO_DATA_OFFSET;
  endfunction

  function automatic logic isLocal(input logic [15:0] dAddr);
    isLocal = (dAddr == ioToData(cae_pkg::LOCAL_FLAG_IO));
  endfunction

  function automatic logic isImm(input cae_pkg::cae_op_t op);
    isImm = op inside {cae_pkg::OP_SUB_IMM, cae_pkg::OP_SUB_CARRY_IMM, cae_pkg::OP_AND_IMM,
                       cae_pkg::OP_OR_IMM, cae_pkg::OP_SET_BITS, cae_pkg::OP_CLR_BITS};
  endfunction

  function automatic logic isByteAlu(input cae_pkg::cae_op_t op);
    isByteAlu = op inside {[cae_pkg::OP_ADD : cae_pkg::OP_TEST]} &&
                op != cae_pkg::OP_WORD_ADD_IMM && op != cae_pkg::OP_WORD_SUB_IMM;
  endfunction

  // ************************************************************
  // command decode
  // ************************************************************
  logic cmdGo;
  cae_pkg::cae_op_t cmdOp;
  cae_pkg::cae_op_t aluOp;
  logic [4:0] pairLo;
  logic [7:0] aluB;
  logic [7:0] aluRes;
  logic [15:0] wordRes;
  logic [7:0] aluSreg;
  logic accLegal;
  logic accRead;
  logic accWrite;
  logic [15:0] accAddr;
  logic [7:0] capVal;
  logic [7:0] rmwVal;
  logic bitVal;
  logic capLocal;
  logic [7:0] flagClr;

  assign cmdOp = cae_pkg::cae_op_t'(wdata[4:0]);
  assign cmdGo = wr && (addr == cae_pkg::REG_CMD) && (state_r == ST_IDLE);
  assign aluOp = (state_r == ST_IDLE) ? cmdOp : op_r;
  assign pairLo = {opDst_r[4:1], 1'b0};
  assign aluB = isImm(aluOp) ? opSrc_r : regFile[opSrc_r[4:0]];
  assign capLocal = isLocal(dataAddr_r);
  assign capVal = capLocal ? flags_r : dataRdata;

  // target address and legality of an access command
  always_comb begin
    accLegal = 1'b1;
    accRead = 1'b0;
    accWrite = 1'b0;
    accAddr = opAddr_r;
    unique case (cmdOp)
      cae_pkg::OP_IO_BIT_SET, cae_pkg::OP_IO_BIT_CLR, cae_pkg::OP_SKIP_BIT_SET,
      cae_pkg::OP_SKIP_BIT_CLR: begin
        accLegal = opAddr_r[15:8] == 8'h00 && opAddr_r[7:0] <= cae_pkg::IO_BIT_LAST;
        accAddr = ioToData(opAddr_r[5:0]);
        accRead = 1'b1;
      end
      cae_pkg::OP_IO_IN, cae_pkg::OP_IO_OUT: begin
        accLegal = (opAddr_r[15:8] == 8'h00) && (opAddr_r[7:0] <= cae_pkg::IO_LAST);
        accAddr = ioToData(opAddr_r[5:0]);
        accRead = (cmdOp == cae_pkg::OP_IO_IN);
        accWrite = (cmdOp == cae_pkg::OP_IO_OUT);
      end
      cae_pkg::OP_LOAD_DIRECT, cae_pkg::OP_STORE_DIRECT: begin
        accAddr = opAddr_r; // extended region reachable here only
        accRead = (cmdOp == cae_pkg::OP_LOAD_DIRECT);
        accWrite = (cmdOp == cae_pkg::OP_STORE_DIRECT);
      end
      default: ;
    endcase
  end

  // ************************************************************
  // datapath instances
  // ************************************************************
  cae_alu u_alu (
    .op(aluOp),
    .a(regFile[opDst_r]),
    .b(aluB),
    .sregIn(sreg_r),
    .wordIn({regFile[pairLo + 5'd1], regFile[pairLo]}),
    .wordK(opSrc_r[5:0]),
    .res(aluRes),
    .wordRes(wordRes),
    .sregOut(aluSreg)
  );

  cae_bit_rmw u_rmw (
    .readVal(capVal),
    .bitSel(opBit_r),
    .setBit(op_r == cae_pkg::OP_IO_BIT_SET),
    .writeVal(rmwVal),
    .bitVal(bitVal)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (cmdGo && accLegal) begin
          if (cmdOp == cae_pkg::OP_WORD_ADD_IMM || cmdOp == cae_pkg::OP_WORD_SUB_IMM) begin
            state_nxt = ST_WORD; // second cycle of the word operation
          end else if (accRead) begin
            state_nxt = ST_ACCESS;
          end else if (accWrite) begin
            state_nxt = ST_WRITE;
          end
        end
      end
      ST_WORD: state_nxt = ST_IDLE;
      ST_ACCESS: state_nxt = ST_CAPTURE;
      ST_CAPTURE: begin
        if (op_r == cae_pkg::OP_IO_BIT_SET || op_r == cae_pkg::OP_IO_BIT_CLR) begin
          state_nxt = ST_WRITE;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WRITE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state, busy and latched operation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      op_r <= cae_pkg::OP_ADD;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      if (cmdGo) begin
        op_r <= cmdOp;
      end
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opDst_r <= 5'h00;
      opSrc_r <= 8'h00;
      opAddr_r <= 16'h0000;
      opBit_r <= 3'h0;
    end else if (wr) begin
      unique case (addr)
        cae_pkg::REG_DST: opDst_r <= wdata[4:0];
        cae_pkg::REG_SRC: opSrc_r <= wdata;
        cae_pkg::REG_ADDR_LO: opAddr_r[7:0] <= wdata;
        cae_pkg::REG_ADDR_HI: opAddr_r[15:8] <= wdata;
        cae_pkg::REG_BIT: opBit_r <= wdata[2:0];
        default: ;
      endcase
    end
  end

  // register file: bus writes, alu results, loaded bytes
  always_ff @(posedge clk) begin
    if (wr && addr >= cae_pkg::REG_FILE_BASE && addr <= cae_pkg::REG_FILE_LAST) begin
      regFile[addr[4:0]] <= wdata;
    end else if (cmdGo && isByteAlu(cmdOp)) begin
      regFile[opDst_r] <= aluRes; // one cycle result
    end else if (state_r == ST_WORD) begin
      regFile[pairLo] <= wordRes[7:0];
      regFile[pairLo + 5'd1] <= wordRes[15:8];
    end else if (state_r == ST_CAPTURE &&
                 (op_r == cae_pkg::OP_IO_IN || op_r == cae_pkg::OP_LOAD_DIRECT)) begin
      regFile[opDst_r] <= capVal;
    end
  end

  // status register: software write or alu update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sreg_r <= cae_pkg::SREG_RESET;
    end else if (wr && addr == cae_pkg::REG_SREG) begin
      sreg_r <= wdata;
    end else if ((cmdGo && isByteAlu(cmdOp)) || state_r == ST_WORD) begin
      sreg_r <= aluSreg;
    end
  end

  // skip result and refused-command error, error is write-one-to-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (cmdGo) begin
        skip_r <= 1'b0;
      end else if (state_r == ST_CAPTURE &&
                   (op_r == cae_pkg::OP_SKIP_BIT_SET || op_r == cae_pkg::OP_SKIP_BIT_CLR)) begin
        skip_r <= (bitVal == (op_r == cae_pkg::OP_SKIP_BIT_SET));
      end
      if ((wr && addr == cae_pkg::REG_CMD && state_r != ST_IDLE) || (cmdGo && !accLegal)) begin
        err_r <= 1'b1; // set wins over clear
      end else if (wr && addr == cae_pkg::REG_STATUS && wdata[cae_pkg::STAT_ERR]) begin
        err_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // local flag register, write one to clear
  // ************************************************************
  always_comb begin
    flagClr = 8'h00;
    if (wr && addr == cae_pkg::REG_FLAGS) begin
      flagClr = wdata;
    end else if (cmdGo && accLegal && accWrite && isLocal(accAddr)) begin
      flagClr = regFile[opDst_r];
    end else if (state_r == ST_CAPTURE && capLocal &&
                 (op_r == cae_pkg::OP_IO_BIT_SET || op_r == cae_pkg::OP_IO_BIT_CLR)) begin
      flagClr = rmwVal; // set flags read back as one are cleared
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= cae_pkg::FLAGS_RESET;
    end else begin
      flags_r <= (flags_r & ~flagClr) | flagEvent; // zero leaves a flag, events win
    end
  end

  // ************************************************************
  // data space access strobes
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataAddr_r <= 16'h0000;
      dataWdata_r <= 8'h00;
      dataWe_r <= 1'b0;
      dataRe_r <= 1'b0;
    end else begin
      dataWe_r <= 1'b0;
      dataRe_r <= 1'b0;
      if (cmdGo && accLegal && (accRead || accWrite)) begin
        dataAddr_r <= accAddr;
        dataWdata_r <= regFile[opDst_r];
        dataRe_r <= accRead && !isLocal(accAddr);
        dataWe_r <= accWrite && !isLocal(accAddr);
      end else if (state_r == ST_CAPTURE &&
                   (op_r == cae_pkg::OP_IO_BIT_SET || op_r == cae_pkg::OP_IO_BIT_CLR)) begin
        dataWdata_r <= rmwVal; // whole register written back
        dataWe_r <= !capLocal;
      end
    end
  end

  // ************************************************************
  // register read port, data one cycle after the strobe
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      if (addr >= cae_pkg::REG_FILE_BASE && addr <= cae_pkg::REG_FILE_LAST) begin
        rdata_r <= regFile[addr[4:0]];
      end else begin
        unique case (addr)
          cae_pkg::REG_DST: rdata_r <= {3'h0, opDst_r};
          cae_pkg::REG_SRC: rdata_r <= opSrc_r;
          cae_pkg::REG_ADDR_LO: rdata_r <= opAddr_r[7:0];
          cae_pkg::REG_ADDR_HI: rdata_r <= opAddr_r[15:8];
          cae_pkg::REG_BIT: rdata_r <= {5'h00, opBit_r};
          cae_pkg::REG_SREG: rdata_r <= sreg_r;
          cae_pkg::REG_STATUS: rdata_r <= {5'h00, err_r, skip_r, busy_r};
          cae_pkg::REG_FLAGS: rdata_r <= flags_r;
          default: rdata_r <= 8'h00;
        endcase
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata = rdata_r;
  assign dataAddr = dataAddr_r;
  assign dataWdata = dataWdata_r;
  assign dataWe = dataWe_r;
  assign dataRe = dataRe_r;
  assign busy = busy_r;
  assign skip = skip_r;

endmodule

// file: tb/cae_core_properties.sv
// concurrent checks on the execution core ports
`timescale 1ns/1ps
module cae_core_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // data space port
  input wire logic [15:0] dataAddr,
  input wire logic [7:0] dataWdata,
  input wire logic dataWe,
  input wire logic dataRe,
  input wire logic [7:0] dataRdata,
  // flags and state
  input wire logic [7:0] flagEvent,
  input wire logic busy,
  input wire logic skip
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic cmdTake;
  // command accepted by an idle core
  assign cmdTake = wr && addr == cae_pkg::REG_CMD && !busy;
  a_byte_one_cycle: assert property (cmdTake && wdata[4:0] inside
    {5'h00, 5'h01, [5'h03:5'h06], [5'h08:5'h0f]} |=> !busy) else $error("byte op busy");
  a_word_two_cycles: assert property (cmdTake && (wdata[4:0] == 5'h02
    || wdata[4:0] == 5'h07) |=> busy ##1 !busy) else $error("word op length");
  a_strobes_exclusive: assert property (!(dataWe && dataRe))
    else $error("both strobes");
  a_rmw_same_addr: assert property (dataRe ##2 dataWe |->
    dataAddr == $past(dataAddr, 2) && dataAddr inside {[16'h0020:16'h003f]})
    else $error("rmw address");
  a_flag_addr_hidden: assert property (dataWe || dataRe |-> dataAddr != 16'h003a)
    else $error("local flag driven out");
  a_skip_cmd_clear: assert property (cmdTake && wdata[4:0] < 5'h18 |=> !skip)
    else $error("skip kept");
  a_read_strobe_pulse: assert property (dataRe |=> !dataRe) else $error("long read");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("busy too long");
endmodule
bind cae_core cae_core_props cae_core_props_inst (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dataAddr(dataAddr), .dataWdata(dataWdata),
  .dataWe(dataWe), .dataRe(dataRe), .dataRdata(dataRdata), .flagEvent(flagEvent),
  .busy(busy), .skip(skip));

// file: tb/cae_mem_model.sv
// far side model: i/o registers and data memory
`timescale 1ns/1ps
module cae_mem_model (
  // clock
  input wire logic clk,
  // data space access
  input wire logic [15:0] dataAddr,
  input wire logic [7:0] dataWdata,
  input wire logic dataWe,
  input wire logic dataRe,
  output logic [7:0] dataRdata
);
  logic [7:0] mem [0:511];
  // memory starts cleared, read bus idles
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    dataRdata = 8'h00;
  end
  // write store; read answers next cycle, then the bus toggles
  always @(posedge clk) begin
    if (dataWe) mem[dataAddr[8:0]] <= dataWdata;
    dataRdata <= dataRe ? mem[dataAddr[8:0]] : ~dataRdata;
  end
endmodule

// file: tb/cae_core_tb.sv
// sequence tests of the execution core
`timescale 1ns/1ps
module cae_core_tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, dataWe, dataRe, busy, skip;
  logic [7:0] addr = 8'h00, wdata = 8'h00, flagEvent = 8'h00, rdata, dataWdata, dataRdata;
  logic [15:0] dataAddr;
  int num_errors = 0, check_count = 0, cycles = 0;
  // ************************************************************
  // clock, instances, watchdog
  // ************************************************************
  initial forever #50 clk = ~clk;
  cae_core cae_core_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .dataAddr(dataAddr), .dataWdata(dataWdata), .dataWe(dataWe),
    .dataRe(dataRe), .dataRdata(dataRdata), .flagEvent(flagEvent), .busy(busy), .skip(skip));
  cae_mem_model cae_mem_model_inst (.clk(clk), .dataAddr(dataAddr), .dataWdata(dataWdata),
    .dataWe(dataWe), .dataRe(dataRe), .dataRdata(dataRdata));
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle bus write and read
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // command write, then bounded wait for idle
  task automatic cmd(input logic [4:0] op);
    int n;
    n = 0;
    wr_reg(cae_pkg::REG_CMD, {3'h0, op});
    #1;
    while (busy !== 1'b0 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 10) chk(8'h01, 8'h00);
  endtask
  // alu op on r25:r24 with source r2 or constant
  task automatic run(input logic [4:0] op, input logic imm, input logic [7:0] pre,
    input logic [15:0] d, input logic [7:0] s, input logic [15:0] e, input logic [7:0] es);
    wr_reg(cae_pkg::REG_SREG, pre);
    wr_reg(8'h38, d[7:0]);
    wr_reg(8'h39, d[15:8]);
    wr_reg(8'h22, s);
    wr_reg(cae_pkg::REG_DST, 8'h18);
    wr_reg(cae_pkg::REG_SRC, imm ? s : 8'h02);
    cmd(op);
    rd_chk(8'h38, e[7:0]);
    rd_chk(8'h39, e[15:8]);
    rd_chk(cae_pkg::REG_SREG, es);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(cae_pkg::REG_FLAGS, cae_pkg::FLAGS_RESET);
    run(5'h00, 1'b0, 8'h10, 16'h000f, 8'h01, 16'h0010, 8'h30);
    run(5'h01, 1'b0, 8'h01, 16'h0080, 8'h7f, 16'h0000, 8'h23);
    run(5'h03, 1'b0, 8'h00, 16'h0000, 8'h01, 16'h00ff, 8'h25);
    run(5'h04, 1'b1, 8'h00, 16'h0080, 8'h01, 16'h007f, 8'h28);
    run(5'h05, 1'b0, 8'h01, 16'h0001, 8'h00, 16'h0000, 8'h02);
    run(5'h06, 1'b1, 8'h01, 16'h0010, 8'h0f, 16'h0000, 8'h22);
    run(5'h02, 1'b1, 8'h20, 16'h7fff, 8'h01, 16'h8000, 8'h2c);
    run(5'h07, 1'b1, 8'h00, 16'h0000, 8'h01, 16'hffff, 8'h15);
    run(5'h08, 1'b0, 8'h2f, 16'h00f0, 8'h80, 16'h0080, 8'h25);
    run(5'h09, 1'b1, 8'h21, 16'h000f, 8'hf0, 16'h0000, 8'h23);
    run(5'h0a, 1'b0, 8'h01, 16'h0000, 8'h00, 16'h0000, 8'h03);
    run(5'h0b, 1'b1, 8'h08, 16'h0001, 8'h80, 16'h0081, 8'h04);
    run(5'h0c, 1'b0, 8'h10, 16'h00ff, 8'hff, 16'h0000, 8'h12);
    run(5'h0d, 1'b1, 8'h00, 16'h0001, 8'h80, 16'h0081, 8'h04);
    run(5'h0e, 1'b1, 8'h20, 16'h00ff, 8'h0f, 16'h00f0, 8'h24);
    run(5'h0f, 1'b0, 8'h0d, 16'h0000, 8'h55, 16'h0000, 8'h03);
    wr_reg(8'h38, 8'h5a);
    wr_reg(cae_pkg::REG_ADDR_LO, 8'h05);
    wr_reg(cae_pkg::REG_ADDR_HI, 8'h00);
    cmd(5'h15);
    chk(cae_mem_model_inst.mem[9'h025], 8'h5a);
    wr_reg(cae_pkg::REG_BIT, 8'h00);
    cmd(5'h10);
    chk(cae_mem_model_inst.mem[9'h025], 8'h5b);
    wr_reg(cae_pkg::REG_BIT, 8'h01);
    cmd(5'h12);
    chk({7'h00, skip}, 8'h01);
    wr_reg(cae_pkg::REG_BIT, 8'h02);
    cmd(5'h13);
    chk({7'h00, skip}, 8'h01);
    wr_reg(cae_pkg::REG_BIT, 8'h00);
    cmd(5'h13);
    chk({7'h00, skip}, 8'h00);
    wr_reg(8'h38, 8'h00);
    cmd(5'h14);
    rd_chk(8'h38, 8'h5b);
    wr_reg(cae_pkg::REG_CMD, 8'h10);
    wr_reg(cae_pkg::REG_CMD, 8'h0f);
    rd_chk(cae_pkg::REG_STATUS, 8'h04);
    wr_reg(cae_pkg::REG_STATUS, 8'h04);
    chk(cae_mem_model_inst.mem[9'h025], 8'h5b);
    wr_reg(cae_pkg::REG_ADDR_LO, 8'h3f);
    cmd(5'h15);
    chk(cae_mem_model_inst.mem[9'h05f], 8'h5b);
    wr_reg(cae_pkg::REG_ADDR_LO, 8'h20);
    cmd(5'h11);
    rd_chk(cae_pkg::REG_STATUS, 8'h04);
    wr_reg(cae_pkg::REG_STATUS, 8'h04);
    rd_chk(cae_pkg::REG_STATUS, 8'h00);
    @(posedge clk);
    flagEvent <= 8'h81;
    @(posedge clk);
    flagEvent <= 8'h00;
    rd_chk(cae_pkg::REG_FLAGS, 8'h81);
    wr_reg(cae_pkg::REG_FLAGS, 8'h01);
    rd_chk(cae_pkg::REG_FLAGS, 8'h80);
    wr_reg(cae_pkg::REG_FLAGS, 8'h00);
    rd_chk(cae_pkg::REG_FLAGS, 8'h80);
    wr_reg(cae_pkg::REG_ADDR_LO, 8'h1a);
    cmd(5'h10);
    rd_chk(cae_pkg::REG_FLAGS, 8'h00);
    wr_reg(8'h38, 8'ha5);
    wr_reg(cae_pkg::REG_ADDR_LO, 8'h00);
    wr_reg(cae_pkg::REG_ADDR_HI, 8'h01);
    cmd(5'h17);
    chk(cae_mem_model_inst.mem[9'h100], 8'ha5);
    wr_reg(8'h38, 8'h00);
    cmd(5'h16);
    rd_chk(8'h38, 8'ha5);
    results();
  end
endmodule
